/* design/mem_space_pkg.sv */
// Purpose: Shared constants and carriers for the memory space addressing block
// Assumes: One core clock, synchronous active-high reset
// Notes:   Special register addresses are the byte addresses seen by direct access
package mem_space_pkg;

	// Space sizes
	localparam int CODE_BYTES  = 8192;
	localparam int EXTERNAL_DATA_SPACE_BYTES = 512;
	localparam int INTERNAL_DATA_SPACE_BYTES = 256;
	localparam int CODE_AW     = 13;
	localparam int EXTERNAL_DATA_SPACE_AW    = 9;

	// Special register addresses
	localparam logic [7:0] SR_PORT_TWO   = 8'hA0;
	localparam logic [7:0] SR_EXTERNAL_DATA_SPACE_PAGE = 8'hA1;
	localparam logic [7:0] SR_DIRECT_MIN = 8'h80;

	// Values after reset
	localparam logic [7:0] XPAGE_RESET    = 8'h00;
	localparam logic [7:0] PORT_TWO_RESET = 8'hFF;

	// Access kinds issued by the core
	typedef enum logic [6:0] {
		ACC_NONE     = 7'b000_0001,
		ACC_FETCH    = 7'b000_0010,
		ACC_CODE_DP  = 7'b000_0100,
		ACC_CODE_PC  = 7'b000_1000,
		ACC_XRI      = 7'b001_0000,
		ACC_XDP      = 7'b010_0000,
		ACC_INTERNAL_DATA_SPACE    = 7'b100_0000
	} acc_kind_e;

	// One request from the core
	typedef struct packed {
		acc_kind_e   kind;
		logic        write;
		logic        direct;    // Internal access by direct address
		logic        ri_sel;    // Working register one when set
		logic [7:0]  acc;
		logic [15:0] data_pointer_register;
		logic [7:0]  extended_data_pointer;
		logic [15:0] pc;
		logic [7:0]  r0;
		logic [7:0]  r1;
		logic [7:0]  iaddr;
		logic [7:0]  wdata;
	} core_req_s;

	// Shared program/external address path
	typedef struct packed {
		logic        code_rd;
		logic        external_data_space_rd;
		logic        external_data_space_wr;
		logic        range_err;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} bus_out_s;

	// Internal space selects
	typedef struct packed {
		logic       ram_rd;
		logic       ram_wr;
		logic       sr_rd;
		logic       sr_wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} int_out_s;

endpackage

/* design/mem_space_addr.sv */
// Purpose: Address generation and space select for program, external and internal data
// Assumes: Core presents one request per cycle; outputs follow one cycle later
// Notes:   Program and external data share one address path
//          Out-of-range accesses are flagged on range_err and lose their strobes
//          A new page value applies to the external move in the very next cycle
// Functional notes
// [RULE1] Separate spaces chosen by instruction type
// [RULE2] Program space spans up to 8K bytes
// [RULE3] Program memory read-only, fetch or code-read
// [RULE4] Pointer code-read uses accumulator plus pointer
// [RULE5] Relative code-read uses accumulator plus counter
// [RULE6] External data space spans up to 512
// [RULE7] External data reached only by external moves
// [RULE8] External data shares program address bus
// [RULE9] Low byte from working register zero/one
// [RULE10] Upper byte from page register at A1h
// [RULE11] Port two writes also load page register
// [RULE12] Pointer form uses extended pointer page
// [RULE13] Internal data space spans 256 bytes
// [RULE14] Direct above 7Fh reaches special registers
`timescale 1ns/1ps

module mem_space_addr (
	input  wire logic                     core_clk_in,
	input  wire logic                     rst_in,
	input  wire mem_space_pkg::core_req_s req_in,
	output mem_space_pkg::bus_out_s       bus_out,
	output mem_space_pkg::int_out_s       int_out,
	output logic [7:0]                    external_data_space_page_high_out,
	output logic [7:0]                    port_two_latch_out
);

	////////////////////////////////////////////////////////////////////////////
	// Helpers

	// Wrap a 16-bit address into a space of the given width; top bit flags overflow
	function automatic logic [16:0] range_check(input logic [15:0] a, input int aw);
		logic [15:0] lim;
		lim = 16'((32'h0000_0001 << aw) - 32'h0000_0001);
		range_check = {(a > lim), a & lim};
	endfunction

	// Direct internal access that lands in the special register window
	function automatic logic is_sr_direct(input mem_space_pkg::core_req_s r);
		is_sr_direct = (r.kind == mem_space_pkg::ACC_INTERNAL_DATA_SPACE) && r.direct &&
		               (r.iaddr >= mem_space_pkg::SR_DIRECT_MIN);
	endfunction

	// Access kinds that read the program space
	function automatic logic is_code_kind(input mem_space_pkg::acc_kind_e k);
		is_code_kind = (k == mem_space_pkg::ACC_FETCH) ||
		               (k == mem_space_pkg::ACC_CODE_DP) ||
		               (k == mem_space_pkg::ACC_CODE_PC);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Page and port two registers

	logic [7:0] external_data_space_page_high_q, external_data_space_page_high_d;
	logic [7:0] port_two_latch_q,  port_two_latch_d;
	logic       sr_write;

	// Next values of the page register and port two
	always_comb begin
		// Only direct writes reach the page and port two; indirect ones go to ram
		sr_write          = is_sr_direct(req_in) && req_in.write;
		external_data_space_page_high_d = external_data_space_page_high_q;
		port_two_latch_d  = port_two_latch_q;
		if (sr_write) begin
			// [RULE10] page register write
			if (req_in.iaddr == mem_space_pkg::SR_EXTERNAL_DATA_SPACE_PAGE) begin
				external_data_space_page_high_d = req_in.wdata;
			end
			// [RULE11] mirror port two
			// Older code pages external data through port two, so keep the page in step
			if (req_in.iaddr == mem_space_pkg::SR_PORT_TWO) begin
				port_two_latch_d  = req_in.wdata;
				external_data_space_page_high_d = req_in.wdata;
			end
		end
	end

	// Register page and port two
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			external_data_space_page_high_q <= mem_space_pkg::XPAGE_RESET;
			port_two_latch_q  <= mem_space_pkg::PORT_TWO_RESET;
		end else begin
			external_data_space_page_high_q <= external_data_space_page_high_d;
			port_two_latch_q  <= port_two_latch_d;
		end
	end

	assign external_data_space_page_high_out = external_data_space_page_high_q;
	assign port_two_latch_out  = port_two_latch_q;

	////////////////////////////////////////////////////////////////////////////
	// Address generation

	mem_space_pkg::bus_out_s bus_q, bus_d;
	logic [16:0]             chk;
	logic [15:0]             raw;
	logic                    is_x;

	// Select space and form address from the access kind
	always_comb begin
		bus_d = '0;
		raw   = 16'h0000;
		is_x  = 1'b0;
		// [RULE1] space by instruction
		case (req_in.kind)
			// Instruction fetch uses the counter as it stands
			mem_space_pkg::ACC_FETCH: begin
				raw = req_in.pc;
			end
			// [RULE4] accumulator plus pointer
			mem_space_pkg::ACC_CODE_DP: begin
				raw = req_in.data_pointer_register + 16'(req_in.acc);    // Wraps at 16 bits
			end
			// [RULE5] accumulator plus counter
			mem_space_pkg::ACC_CODE_PC: begin
				raw = req_in.pc + 16'(req_in.acc);      // Wraps at 16 bits
			end
			// [RULE9] low byte from register
			mem_space_pkg::ACC_XRI: begin
				is_x = 1'b1;
				// [RULE10] upper byte from page
				raw  = {external_data_space_page_high_q, req_in.ri_sel ? req_in.r1 : req_in.r0};
			end
			// [RULE12] extended pointer page
			mem_space_pkg::ACC_XDP: begin
				is_x = 1'b1;
				raw  = req_in.data_pointer_register;
			end
			// Idle and internal accesses leave the shared path quiet
			default: begin
				raw = 16'h0000;
			end
		endcase
		// [RULE2] [RULE6] space limits
		chk = range_check(raw, is_x ? mem_space_pkg::EXTERNAL_DATA_SPACE_AW : mem_space_pkg::CODE_AW);
		// [RULE12] page bits join above pointer
		// Only page zero exists, so any other extended page is out of range
		if (req_in.kind == mem_space_pkg::ACC_XDP) begin
			chk[16] = chk[16] | (req_in.extended_data_pointer != 8'h00);
		end
		// [RULE8] one shared address path
		bus_d.addr      = chk[15:0];
		bus_d.wdata     = req_in.wdata;
		// Flag the wrapped address as well, so a stray access never strobes a real byte
		bus_d.range_err = chk[16] && (req_in.kind != mem_space_pkg::ACC_NONE) &&
		                  (req_in.kind != mem_space_pkg::ACC_INTERNAL_DATA_SPACE);
		// [RULE3] program space is read-only
		// A write aimed at program space gets no strobe at all
		bus_d.code_rd  = is_code_kind(req_in.kind) && !req_in.write;
		// [RULE7] only external moves reach it
		bus_d.external_data_space_rd = is_x && !req_in.write;
		bus_d.external_data_space_wr = is_x && req_in.write;
		// Refused accesses keep their address masked to the space width but lose every strobe
		if (bus_d.range_err) begin
			bus_d.code_rd  = 1'b0;
			bus_d.external_data_space_rd = 1'b0;
			bus_d.external_data_space_wr = 1'b0;
		end
	end

	// Register the shared address path
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			bus_q <= '0;
		end else begin
			bus_q <= bus_d;
		end
	end

	assign bus_out = bus_q;

	////////////////////////////////////////////////////////////////////////////
	// Internal data space

	mem_space_pkg::int_out_s int_q, int_d;

	// Split internal accesses between ram and special registers
	always_comb begin
		int_d = '0;
		// [RULE13] internal 256-byte space
		if (req_in.kind == mem_space_pkg::ACC_INTERNAL_DATA_SPACE) begin
			// Eight address bits cover the whole space, so nothing is refused
			int_d.addr  = req_in.iaddr;
			int_d.wdata = req_in.wdata;
			// [RULE14] direct upper half is special registers
			if (is_sr_direct(req_in)) begin
				int_d.sr_rd = !req_in.write;
				int_d.sr_wr = req_in.write;
			end else begin
				// Indirect access to the upper half stays in ram
				int_d.ram_rd = !req_in.write;
				int_d.ram_wr = req_in.write;
			end
		end
	end

	// Register the internal selects
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			int_q <= '0;
		end else begin
			int_q <= int_d;
		end
	end

	assign int_out = int_q;

endmodule // mem_space_addr

/* testbench/mem_space_props.sv */
// Purpose: Port relations of the address block
// Assumes: Answers come one cycle after a request
// Notes:   Bound to every address block
`timescale 1ns/1ps
module mem_space_props (
	input wire logic                     core_clk_in,
	input wire logic                     rst_in,
	input wire mem_space_pkg::core_req_s req_in,
	input wire mem_space_pkg::bus_out_s  bus_out,
	input wire mem_space_pkg::int_out_s  int_out,
	input wire logic [7:0]               external_data_space_page_high_out,
	input wire logic [7:0]               port_two_latch_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	// Request decode helpers
	wire logic [15:0] dp_sum = req_in.data_pointer_register + {8'h00, req_in.acc};
	wire logic [15:0] pc_sum = req_in.pc + {8'h00, req_in.acc};
	wire logic [7:0]  ri_val = req_in.ri_sel ? req_in.r1 : req_in.r0;
	wire logic        xdp_bad = req_in.extended_data_pointer != 8'h00 || req_in.data_pointer_register[15:9] != 7'h00;
	wire logic        is_x = req_in.kind[5:4] != 2'b00;
	wire logic        is_code = req_in.kind[3:1] != 3'b000;
	wire logic        is_int = req_in.kind == mem_space_pkg::ACC_INTERNAL_DATA_SPACE;
	sequence p2_wr_s;
		is_int && req_in.direct && req_in.write && req_in.iaddr == 8'hA0;
	endsequence
	ri_low_a: assert property (req_in.kind == mem_space_pkg::ACC_XRI |=>
		bus_out.addr[7:0] == $past(ri_val)) else $error("register low byte wrong");
	page_hi_a: assert property (req_in.kind == mem_space_pkg::ACC_XRI |=>
		bus_out.addr[8] == $past(external_data_space_page_high_out[0])) else $error("page bit wrong");
	p2_page_a: assert property (p2_wr_s |=> external_data_space_page_high_out == $past(req_in.wdata))
		else $error("port two write missed page");
	code_dp_a: assert property (req_in.kind == mem_space_pkg::ACC_CODE_DP |=>
		bus_out.addr[12:0] == $past(dp_sum[12:0])) else $error("pointer code address wrong");
	code_pc_a: assert property (req_in.kind == mem_space_pkg::ACC_CODE_PC |=>
		bus_out.code_rd == ($past(pc_sum) < 16'h2000 && !$past(req_in.write)))
		else $error("relative code read wrong");
	code_ro_a: assert property (is_code && req_in.write |=>
		!bus_out.code_rd && !bus_out.external_data_space_wr) else $error("code write strobed");
	xmove_only_a: assert property (!is_x |=> !bus_out.external_data_space_rd && !bus_out.external_data_space_wr)
		else $error("external strobe without move");
	xdp_err_a: assert property (req_in.kind == mem_space_pkg::ACC_XDP |=>
		bus_out.range_err == $past(xdp_bad)) else $error("pointer page check wrong");
	sr_direct_a: assert property (is_int && req_in.direct && req_in.iaddr[7] |=>
		!int_out.ram_rd && !int_out.ram_wr) else $error("direct high reached ram");
	ram_ind_a: assert property (is_int && !req_in.direct |=>
		int_out.addr == $past(req_in.iaddr)) else $error("indirect address wrong");
endmodule // mem_space_props

bind mem_space_addr mem_space_props props_i (.core_clk_in(core_clk_in), .rst_in(rst_in),
	.req_in(req_in), .bus_out(bus_out), .int_out(int_out),
	.external_data_space_page_high_out(external_data_space_page_high_out), .port_two_latch_out(port_two_latch_out));

/* testbench/core_model.sv */
// Purpose: Core model issuing access requests
// Assumes: Requests change at the falling edge
// Notes:   One request cycle, then idle
`timescale 1ns/1ps
module core_model (
	input  wire logic                core_clk_in,
	output mem_space_pkg::core_req_s req_out
);
	// Idle until a request is issued
	initial req_out = '{kind: mem_space_pkg::ACC_NONE, default: '0};
	// Hold one request across one rising edge
	task automatic issue(input mem_space_pkg::core_req_s r);
		@(negedge core_clk_in);
		req_out = r;
		@(negedge core_clk_in);
		req_out = '{kind: mem_space_pkg::ACC_NONE, default: '0};
	endtask
endmodule // core_model

/* testbench/mem_space_addr_test.sv */
// Purpose: Self-checking bench of the address block
// Assumes: Answers checked one cycle after each request
// Notes:   Strobes packed as code, xrd, xwr, err
`timescale 1ns/1ps
module mem_space_addr_test;
	logic                     core_clk_in;
	logic                     rst_in = 1'b1;
	mem_space_pkg::core_req_s req;
	mem_space_pkg::core_req_s r;
	mem_space_pkg::bus_out_s  bus;
	mem_space_pkg::int_out_s  io;
	logic [7:0]               pg;
	logic [7:0]               p2;
	int                       miscompares = 0;
	int                       checked = 0;
	core_model core (.core_clk_in(core_clk_in), .req_out(req));
	mem_space_addr DUT (.core_clk_in(core_clk_in), .rst_in(rst_in), .req_in(req),
		.bus_out(bus), .int_out(io), .external_data_space_page_high_out(pg), .port_two_latch_out(p2));
	// Clock of 25 ns
	initial begin
		core_clk_in = 1'b0;
		forever #12.5 core_clk_in = ~core_clk_in;
	end
	function automatic mem_space_pkg::core_req_s mk(input mem_space_pkg::acc_kind_e k,
		input logic w, input logic d, input logic [15:0] p, input logic [7:0] a, b);
		mk = '{kind: k, write: w, direct: d, data_pointer_register: p, pc: p, acc: a, r0: a, iaddr: a,
			r1: b, wdata: b, default: '0};
	endfunction
	function automatic logic [15:0] st();
		st = {12'h000, bus.code_rd, bus.external_data_space_rd, bus.external_data_space_wr, bus.range_err};
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic close_out();
		if (miscompares == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Port two write loads the page, then paged moves
	task automatic t_paged();
		core.issue(mk(mem_space_pkg::ACC_INTERNAL_DATA_SPACE, 1, 1, 0, 8'hA0, 8'h01));
		chk({8'h00, pg}, 16'h0001);
		chk({15'h0, io.sr_wr}, 16'h0001);
		core.issue(mk(mem_space_pkg::ACC_XRI, 0, 0, 0, 8'h56, 8'h34));
		chk(bus.addr, 16'h0156);
		chk(st(), 16'h0004);
		r = mk(mem_space_pkg::ACC_XRI, 1, 0, 0, 8'h56, 8'h34);
		r.ri_sel = 1'b1;
		core.issue(r);
		chk(bus.addr, 16'h0134);
		chk(st(), 16'h0002);
		core.issue(mk(mem_space_pkg::ACC_INTERNAL_DATA_SPACE, 1, 1, 0, 8'hA1, 8'h02));
		chk({pg, p2}, 16'h0201);
		core.issue(mk(mem_space_pkg::ACC_XRI, 0, 0, 0, 8'h56, 8'h34));
		chk(st(), 16'h0001);
	endtask
	// Fetch, code reads at the space edge and a refused write
	task automatic t_code();
		core.issue(mk(mem_space_pkg::ACC_FETCH, 0, 0, 16'h0ABC, 0, 0));
		chk(bus.addr, 16'h0ABC);
		chk(st(), 16'h0008);
		core.issue(mk(mem_space_pkg::ACC_CODE_DP, 0, 0, 16'h1F00, 8'hFF, 0));
		chk(bus.addr, 16'h1FFF);
		chk(st(), 16'h0008);
		core.issue(mk(mem_space_pkg::ACC_CODE_PC, 0, 0, 16'h1FFF, 8'h01, 0));
		chk(st(), 16'h0001);
		core.issue(mk(mem_space_pkg::ACC_CODE_DP, 1, 0, 16'h0010, 8'h01, 8'h77));
		chk(st(), 16'h0000);
	endtask
	// Pointer moves and internal space decode
	task automatic t_data();
		core.issue(mk(mem_space_pkg::ACC_XDP, 1, 0, 16'h01FF, 0, 8'h5A));
		chk({bus.wdata, 4'h0, bus.code_rd, bus.external_data_space_rd, bus.external_data_space_wr, bus.range_err},
			16'h5A02);
		r = mk(mem_space_pkg::ACC_XDP, 0, 0, 16'h0010, 0, 0);
		r.extended_data_pointer = 8'h01;
		core.issue(r);
		chk(st(), 16'h0001);
		core.issue(mk(mem_space_pkg::ACC_INTERNAL_DATA_SPACE, 0, 0, 0, 8'h90, 0));
		chk({io.addr, 4'h0, io.ram_rd, io.sr_rd, bus.external_data_space_wr, bus.range_err}, 16'h9008);
		core.issue(mk(mem_space_pkg::ACC_INTERNAL_DATA_SPACE, 1, 0, 0, 8'hA0, 8'h3C));
		chk({io.wdata, 6'h00, io.ram_wr, io.sr_wr}, 16'h3C02);
		chk({pg, p2}, 16'h0201);
		core.issue(mk(mem_space_pkg::ACC_INTERNAL_DATA_SPACE, 0, 1, 0, 8'hA1, 0));
		chk({io.addr, 6'h00, io.sr_rd, io.ram_rd}, 16'hA102);
	endtask
	initial begin
		repeat (6) @(negedge core_clk_in);
		rst_in = 1'b0;
		chk({pg, p2}, 16'h00FF);
		t_paged();
		t_code();
		t_data();
		close_out();
	end
	// Watchdog
	initial begin
		#10000;
		miscompares++;
		close_out();
	end
endmodule // mem_space_addr_test
